// ### dv/abd_bin_src.sv
`timescale 1ns/10ps

// -----------------------------------
// Bin source
// -----------------------------------
// Sends bins 0 to 49 one per cycle, or every other cycle in slow mode.
// Idle lines toggle, so stale data is never mistaken for a bin.
module abd_bin_src (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic slow_i,
   input wire logic [23:0] e_lo_i,
   input wire logic [23:0] e_hi_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [5:0] idx_o,
   output logic [23:0] energy_o,
   output logic done_o
);
   logic [5:0] k;
   logic run;
   logic ph;

   // Walks the bins, then marks the frame complete.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run <= 1'b0;
         k <= 6'h00;
         ph <= 1'b0;
         valid_o <= 1'b0;
         done_o <= 1'b0;
         idx_o <= 6'h00;
         energy_o <= 24'h000000;
      end else begin
         valid_o <= 1'b0;
         done_o <= 1'b0;
         ph <= ~ph;
         idx_o <= ~idx_o;
         energy_o <= ~energy_o;
         if (go_i) begin
            run <= 1'b1;
            k <= 6'h00;
         end else if (run && ready_i && !(slow_i && ph)) begin
            if (k == 6'h32) begin
               done_o <= 1'b1;
               run <= 1'b0;
            end else begin
               valid_o <= 1'b1;
               idx_o <= k;
               energy_o <= (k < 6'h17) ? e_lo_i : e_hi_i;
               k <= k + 6'h01;
            end
         end
      end
   end
endmodule

// ### dv/abd_top_tb.sv
`timescale 1ns/10ps

module abd_top_tb;
   logic CLK_I, SYS_RST_I, PSEL_I, PENABLE_I, PWRITE_I;
   logic [7:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O;
   logic PREADY_O, PSLVERR_O, BIN_VALID_I, BIN_READY_O, FRAME_DONE_I;
   logic ACTIVITY_DECISION_I, BW_VALID_O, go, slow;
   logic [5:0] BIN_IDX_I;
   logic [23:0] BIN_ENERGY_I, e_lo, e_hi;
   logic [15:0] NOISE_LVL_I;
   logic [1:0] SELECTED_BANDWIDTH_O, bw;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int num_checks = 0;

   abd_top u_abd_top (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
      .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
      .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
      .BIN_VALID_I(BIN_VALID_I), .BIN_IDX_I(BIN_IDX_I), .BIN_ENERGY_I(BIN_ENERGY_I),
      .BIN_READY_O(BIN_READY_O), .FRAME_DONE_I(FRAME_DONE_I),
      .ACTIVITY_DECISION_I(ACTIVITY_DECISION_I), .NOISE_LVL_I(NOISE_LVL_I),
      .SELECTED_BANDWIDTH_O(SELECTED_BANDWIDTH_O), .BW_VALID_O(BW_VALID_O));
   abd_bin_src u_abd_bin_src (.clk_i(CLK_I), .rst_i(SYS_RST_I), .go_i(go), .slow_i(slow),
      .e_lo_i(e_lo), .e_hi_i(e_hi), .ready_i(BIN_READY_O), .valid_o(BIN_VALID_I),
      .idx_o(BIN_IDX_I), .energy_o(BIN_ENERGY_I), .done_o(FRAME_DONE_I));

   // Clock at 200 MHz.
   initial begin
      CLK_I = 1'b0;
      forever #2.5 CLK_I = ~CLK_I;
   end

   // Prints the counts and the verdict, then stops.
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Compares one value and counts it.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (PREADY_O !== 1'b1 && n < 20);
      if (PREADY_O !== 1'b1) begin
         err_count++;
         test_done();
      end
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask

   // Runs one frame and checks the answer delay and the ready gap.
   task frm(input int lat);
      int n;
      go <= 1'b1;
      @(posedge CLK_I);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (FRAME_DONE_I !== 1'b1 && n < 400);
      if (FRAME_DONE_I !== 1'b1) begin
         err_count++;
         test_done();
      end
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
         if (n < lat) chk(BIN_READY_O, 0);
      end while (BW_VALID_O !== 1'b1 && n < 40);
      if (BW_VALID_O !== 1'b1) begin
         err_count++;
         test_done();
      end
      chk(n, lat);
      bw = SELECTED_BANDWIDTH_O;
   endtask

   // Reset values, an unmapped place and a read-only write.
   task t_regs();
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000000d);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h00000084);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, er}, 1);
      apb(1'b1, 8'h0c, 32'hffffffff);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
   endtask

   // Long-term means move only when active and noise is above 30 dB.
   task t_ltm();
      ACTIVITY_DECISION_I <= 1'b0;
      NOISE_LVL_I <= 16'h2800;
      frm(15);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      ACTIVITY_DECISION_I <= 1'b1;
      NOISE_LVL_I <= 16'h1e00;
      slow <= 1'b1;
      frm(15);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      NOISE_LVL_I <= 16'h1e01;
      frm(15);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd === 32'h0}, 0);
      slow <= 1'b0;
   endtask

   // Wide spectrum: counters climb until full class is chosen, then the rate clamps it.
   task t_clamp();
      e_hi <= 24'hffffff;
      apb(1'b1, 8'h04, 32'h60);
      for (int i = 0; i < 92; i++) begin
         frm(15);
         chk({31'h0, bw === 2'h3}, 0);
      end
      chk(bw, 2'h2);
      apb(1'b1, 8'h04, 32'h48);
      for (int i = 0; i < 4; i++) begin
         frm(15);
         chk(bw, 2'h1);
      end
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, rd[6:0] > 7'h64 || rd[14:8] > 7'h64 || rd[22:16] > 7'h64}, 0);
      chk(rd, 32'h00606464);
   endtask

   // At 32 kHz the top bands are floored; at 8 kHz no detection runs; legacy keeps the timing.
   task t_modes();
      logic [31:0] c;
      apb(1'b1, 8'h00, 32'h9);
      frm(15);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h005f6464);
      c = rd;
      apb(1'b1, 8'h00, 32'h1);
      frm(2);
      chk(bw, 0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, c);
      apb(1'b1, 8'h00, 32'hf);
      frm(15);
   endtask

   // Main sequence.
   initial begin
      {PSEL_I, PENABLE_I, PWRITE_I, go, slow, ACTIVITY_DECISION_I} = 6'h00;
      {PADDR_I, PWDATA_I, NOISE_LVL_I} = 56'h0;
      e_lo = 24'h100000;
      e_hi = 24'h000010;
      SYS_RST_I = 1'b1;
      repeat (6) @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      t_regs();
      t_ltm();
      t_clamp();
      t_modes();
      test_done();
   end
endmodule

// ### logic/abd_consts.svh
`ifndef ABD_CONSTS_SVH
`define ABD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------------
`define ABD_CTRL_OFS 8'h00
`define ABD_BITRATE_OFS 8'h04
`define ABD_STAT_OFS 8'h08
`define ABD_CNT_OFS 8'h0c
`define ABD_LTM0_OFS 8'h10
`define ABD_LTM1_OFS 8'h14
`define ABD_CTRL_RST 4'hd
`define ABD_BITRATE_RST 11'h084
`define ABD_EN_BIT 0
`define ABD_LEGACY_BIT 1
`define ABD_RATE_LSB 2

// ----------------------------------------------------------------------------
// Band layout: first bin of bands 8 down to 0, each band spans four bins
// ----------------------------------------------------------------------------
`define ABD_BAND_STARTS {6'h2e, 6'h2a, 6'h23, 6'h1f, 6'h1b, 6'h17, 6'h0e, 6'h0b, 6'h03}
`define ABD_BAND_SPAN 6'h03
`define ABD_NBANDS_8K 4'h1
`define ABD_NBANDS_16K 4'h3
`define ABD_NBANDS_32K 4'h7
`define ABD_NBANDS_48K 4'h9

// ----------------------------------------------------------------------------
// Log-domain constants, signed Q8 (value times 256)
// ----------------------------------------------------------------------------
// Offset log10(8 * f * f) for f = 88.283854, 88.300926, 88.304118, 88.028412.
`define ABD_SCL_8K 16'h04cb
`define ABD_SCL_16K 16'h04cc
`define ABD_SCL_32K 16'h04cc
`define ABD_SCL_48K 16'h04cb
`define ABD_OFS_1P6 16'h019a
`define ABD_NOISE_MIN 16'h1e00
`define ABD_LOG_FLOOR 16'he000
`define ABD_LOG10_2_Q8 8'h4d

// ----------------------------------------------------------------------------
// Counter thresholds, filterbank path then transform path
// ----------------------------------------------------------------------------
`define ABD_FB_THR_WB_MAX 16'h0100
`define ABD_FB_THR_WB_LT 16'h00c0
`define ABD_FB_THR_SWB_MAX 16'h00e0
`define ABD_FB_THR_SWB_LT 16'h00a0
`define ABD_FB_THR_FB_MAX 16'h00c0
`define ABD_FB_THR_FB_MEAN 16'h0080
`define ABD_TD_THR_WB_MAX 16'h0600
`define ABD_TD_THR_WB_LT 16'h0500
`define ABD_TD_THR_SWB_MAX 16'h0580
`define ABD_TD_THR_SWB_LT 16'h0480
`define ABD_TD_THR_FB_MAX 16'h0500
`define ABD_TD_THR_FB_MEAN 16'h0400
`define ABD_CNT_MAX 7'h64
`define ABD_CNT_HI 7'h5a

// ----------------------------------------------------------------------------
// Bitrate limits in units of 0.1 kbps
// ----------------------------------------------------------------------------
`define ABD_BR_NB_MAX 11'h0f4
`define ABD_BR_SWB_MIN 11'h060
`define ABD_BR_FB_MIN 11'h0a4
`define ABD_BR_9K6 11'h060

`endif

// ### logic/abd_log10.sv
`timescale 1ns/10ps
`include "abd_consts.svh"

// Base-10 logarithm of an unsigned energy, signed Q8 result.
module abd_log10 #(
   parameter int IW = 32,
   parameter int FW = 8
) (
   input wire logic [IW-1:0] energy_i,
   output logic [15:0] log_o,
   output logic zero_o
);

   // ------------------------------------------------------------------------
   // Leading one gives the integer part, the bits below it a linear fraction.
   // ------------------------------------------------------------------------
   always_comb begin
      logic [4:0] msb;
      logic [IW-1:0] norm;
      logic [12:0] log2q;
      logic [20:0] prod;
      msb = 5'h00;
      norm = '0;
      log2q = 13'h0000;
      prod = 21'h000000;
      for (int i = 0; i < IW; i++) begin
         if (energy_i[i]) begin
            msb = 5'(i);
         end
      end
      norm = energy_i << (5'(IW - 1) - msb);
      log2q = {msb, norm[IW-2 -: FW]};
      prod = 21'(log2q) * 21'(`ABD_LOG10_2_Q8);
      log_o = 16'(prod >> 8);
      zero_o = (energy_i == '0);
   end

endmodule

// ### logic/abd_pkg.sv
package abd_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_LOG = 4'b0001,
      ST_CLASS = 4'b0010,
      ST_LTM = 4'b0011,
      ST_CNT = 4'b0100,
      ST_SEL = 4'b0101,
      ST_LIMIT = 4'b0110
   } abd_state_t;

   typedef enum logic [1:0] {
      NARROW_CLASS = 2'b00,
      WIDE_CLASS = 2'b01,
      SUPER_WIDE_CLASS = 2'b10,
      FULL_CLASS = 2'b11
   } abd_bw_t;

   typedef struct packed {
      abd_state_t st;
      logic [3:0] idx;
      logic [8:0][31:0] acc;
      logic [8:0][15:0] lg;
      logic [15:0] m_nb;
      logic [15:0] m_wb;
      logic [15:0] m_swb;
      logic [15:0] m_fb;
      logic [15:0] x_wb;
      logic [15:0] x_swb;
      logic [15:0] x_fb;
      logic [15:0] lt_nb;
      logic [15:0] lt_wb;
      logic [15:0] lt_swb;
      logic [6:0] c_wb;
      logic [6:0] c_swb;
      logic [6:0] c_fb;
      abd_bw_t sel;
      logic activity_decision;
      logic noise_ok;
      logic [3:0] ctrl;
      logic [10:0] bitrate;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [1:0] bw;
      logic bw_vld;
      logic bin_rdy;
      logic [7:0] frames;
   } abd_regs_t;

endpackage

// ### logic/abd_top.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "abd_consts.svh"

module abd_top #(
   parameter int EW = 24
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic BIN_VALID_I,
   input wire logic [5:0] BIN_IDX_I,
   input wire logic [EW-1:0] BIN_ENERGY_I,
   output logic BIN_READY_O,
   input wire logic FRAME_DONE_I,
   input wire logic ACTIVITY_DECISION_I,
   input wire logic [15:0] NOISE_LVL_I,
   output logic [1:0] SELECTED_BANDWIDTH_O,
   output logic BW_VALID_O
);

   localparam logic [53:0] BAND_STARTS = `ABD_BAND_STARTS;

   abd_pkg::abd_regs_t r;
   abd_pkg::abd_regs_t n;
   logic [15:0] log_val;
   logic log_zero;
   logic legacy;
   logic [1:0] rate;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------

   // Signed maximum of two Q8 values.
   function automatic logic [15:0] smax(input logic [15:0] a, input logic [15:0] b);
      smax = ($signed(a) > $signed(b)) ? a : b;
   endfunction

   // Counter step that stays inside 0 to 100.
   function automatic logic [6:0] step(input logic [6:0] c, input logic up);
      if (up) begin
         step = (c >= `ABD_CNT_MAX) ? `ABD_CNT_MAX : c + 7'h01;
      end else begin
         step = (c == 7'h00) ? 7'h00 : c - 7'h01;
      end
   endfunction

   // Threshold table for each path.
   function automatic logic [15:0] thr(input logic td, input logic [2:0] k);
      case (k)
         3'h0: thr = td ? `ABD_TD_THR_WB_MAX : `ABD_FB_THR_WB_MAX;
         3'h1: thr = td ? `ABD_TD_THR_WB_LT : `ABD_FB_THR_WB_LT;
         3'h2: thr = td ? `ABD_TD_THR_SWB_MAX : `ABD_FB_THR_SWB_MAX;
         3'h3: thr = td ? `ABD_TD_THR_SWB_LT : `ABD_FB_THR_SWB_LT;
         3'h4: thr = td ? `ABD_TD_THR_FB_MAX : `ABD_FB_THR_FB_MAX;
         default: thr = td ? `ABD_TD_THR_FB_MEAN : `ABD_FB_THR_FB_MEAN;
      endcase
   endfunction

   assign legacy = r.ctrl[`ABD_LEGACY_BIT];
   assign rate = r.ctrl[`ABD_RATE_LSB +: 2];

   // ------------------------------------------------------------------------
   // Log converter, one band per cycle
   // ------------------------------------------------------------------------
   abd_log10 #(
      .IW(32),
      .FW(8)
   ) u_log (
      .energy_i(r.acc[r.idx]),
      .log_o(log_val),
      .zero_o(log_zero)
   );

   // ------------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------------
   always_comb begin
      logic [3:0] nbands;
      logic [15:0] scl;
      logic [15:0] ofs;
      logic [17:0] s;
      logic hit;
      logic [5:0] bs;
      abd_pkg::abd_bw_t b;
      nbands = 4'h0;
      scl = 16'h0000;
      ofs = 16'h0000;
      s = 18'h00000;
      hit = 1'b0;
      bs = 6'h00;
      b = abd_pkg::NARROW_CLASS;
      n = r;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.bw_vld = 1'b0;

      // Rate-dependent band count and log offset.
      case (rate)
         2'b00: begin
            nbands = `ABD_NBANDS_8K;
            scl = `ABD_SCL_8K;
         end
         2'b01: begin
            nbands = `ABD_NBANDS_16K;
            scl = `ABD_SCL_16K;
         end
         2'b10: begin
            nbands = `ABD_NBANDS_32K;
            scl = `ABD_SCL_32K;
         end
         default: begin
            nbands = `ABD_NBANDS_48K;
            scl = `ABD_SCL_48K;
         end
      endcase
      ofs = legacy ? 16'h0000 : `ABD_OFS_1P6;

      // APB: answer in the first access cycle, writes land at that edge.
      if (PSEL_I && !PENABLE_I) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         case (PADDR_I)
            `ABD_CTRL_OFS: n.prdata = {28'h0000000, r.ctrl};
            `ABD_BITRATE_OFS: n.prdata = {21'h000000, r.bitrate};
            `ABD_STAT_OFS: n.prdata = {16'h0000, r.frames, 5'h00, (r.st != abd_pkg::ST_IDLE), r.bw};
            `ABD_CNT_OFS: n.prdata = {9'h000, r.c_fb, 1'b0, r.c_swb, 1'b0, r.c_wb};
            `ABD_LTM0_OFS: n.prdata = {r.lt_wb, r.lt_nb};
            `ABD_LTM1_OFS: n.prdata = {16'h0000, r.lt_swb};
            default: n.pslverr = 1'b1;
         endcase
      end
      if (PSEL_I && PENABLE_I && r.pready && PWRITE_I) begin
         case (PADDR_I)
            `ABD_CTRL_OFS: n.ctrl = PWDATA_I[3:0];
            `ABD_BITRATE_OFS: n.bitrate = PWDATA_I[10:0];
            default: ;
         endcase
      end

      case (r.st)
         abd_pkg::ST_IDLE: begin
            // Gather bins into bands; transform path delivers one value per band.
            if (BIN_VALID_I) begin
               for (int i = 0; i < 9; i++) begin
                  bs = BAND_STARTS[i*6 +: 6];
                  if (legacy) begin
                     hit = (BIN_IDX_I == 6'(i));
                  end else begin
                     hit = (BIN_IDX_I >= bs) && (BIN_IDX_I <= bs + `ABD_BAND_SPAN);
                  end
                  if (hit) begin
                     n.acc[i] = r.acc[i] + 32'(BIN_ENERGY_I);
                  end
               end
            end
            if (FRAME_DONE_I && r.ctrl[`ABD_EN_BIT]) begin
               n.activity_decision = ACTIVITY_DECISION_I;
               n.noise_ok = $signed(NOISE_LVL_I) > $signed(`ABD_NOISE_MIN);
               n.idx = 4'h0;
               n.st = (rate == 2'b00) ? abd_pkg::ST_LIMIT : abd_pkg::ST_LOG;
            end
         end
         abd_pkg::ST_LOG: begin
            // Bands beyond the rate's reach are floored.
            if (r.idx >= nbands || log_zero) begin
               n.lg[r.idx] = `ABD_LOG_FLOOR;
            end else if (legacy) begin
               n.lg[r.idx] = log_val;
            end else begin
               n.lg[r.idx] = log_val - scl;
            end
            n.acc[r.idx] = 32'h0000_0000;
            n.idx = r.idx + 4'h1;
            if (r.idx == 4'h8) begin
               n.st = abd_pkg::ST_CLASS;
            end
         end
         abd_pkg::ST_CLASS: begin
            // Class means and maxima; offset is zero on the transform path.
            n.m_nb = r.lg[0] + ofs;
            s = 18'($signed(r.lg[1])) + 18'($signed(r.lg[2]));
            n.m_wb = 16'(s >> 1) + ofs;
            s = 18'($signed(r.lg[3])) + 18'($signed(r.lg[4])) + 18'($signed(r.lg[5])) + 18'($signed(r.lg[6]));
            n.m_swb = 16'($signed(s) >>> 2) + ofs;
            s = 18'($signed(r.lg[7])) + 18'($signed(r.lg[8]));
            n.m_fb = 16'($signed(s) >>> 1) + ofs;
            n.x_wb = smax(r.lg[1], r.lg[2]) + ofs;
            n.x_swb = smax(smax(r.lg[3], r.lg[4]), smax(r.lg[5], r.lg[6])) + ofs;
            n.x_fb = smax(r.lg[7], r.lg[8]) + ofs;
            n.st = abd_pkg::ST_LTM;
         end
         abd_pkg::ST_LTM: begin
            // Long-term means follow only active frames over the noise floor.
            if (r.activity_decision && r.noise_ok) begin
               n.lt_nb = r.lt_nb - 16'($signed(r.lt_nb) >>> 2) + 16'($signed(r.m_nb) >>> 2);
               n.lt_wb = r.lt_wb - 16'($signed(r.lt_wb) >>> 2) + 16'($signed(r.m_wb) >>> 2);
               n.lt_swb = r.lt_swb - 16'($signed(r.lt_swb) >>> 2) + 16'($signed(r.m_swb) >>> 2);
            end
            n.st = abd_pkg::ST_CNT;
         end
         abd_pkg::ST_CNT: begin
            // Wide first, then super-wide, then full; each sees the one before.
            n.c_wb = step(r.c_wb, ($signed(r.x_wb) > $signed(thr(legacy, 3'h0))) &&
                                  ($signed(r.lt_wb) > $signed(thr(legacy, 3'h1))));
            n.c_swb = step(r.c_swb, (n.c_wb != 7'h00) &&
                                    ($signed(r.x_swb) > $signed(thr(legacy, 3'h2))) &&
                                    ($signed(r.lt_swb) > $signed(thr(legacy, 3'h3))));
            n.c_fb = step(r.c_fb, (n.c_swb != 7'h00) &&
                                  ($signed(r.x_fb) > $signed(thr(legacy, 3'h4))) &&
                                  ($signed(r.m_fb) > $signed(thr(legacy, 3'h5))));
            n.st = abd_pkg::ST_SEL;
         end
         abd_pkg::ST_SEL: begin
            // Later tests may overwrite earlier choices.
            if (r.c_wb == 7'h00) begin
               n.sel = abd_pkg::NARROW_CLASS;
               n.c_swb = 7'h00;
               n.c_fb = 7'h00;
            end
            if (r.c_wb >= `ABD_CNT_HI && n.sel == abd_pkg::NARROW_CLASS) begin
               n.sel = abd_pkg::WIDE_CLASS;
            end
            if (r.c_swb >= `ABD_CNT_HI && n.sel != abd_pkg::FULL_CLASS) begin
               n.sel = abd_pkg::SUPER_WIDE_CLASS;
               n.c_wb = `ABD_CNT_MAX;
            end
            if (r.c_fb >= `ABD_CNT_HI) begin
               n.sel = abd_pkg::FULL_CLASS;
               n.c_wb = `ABD_CNT_MAX;
               n.c_swb = `ABD_CNT_MAX;
            end
            if (n.sel == abd_pkg::FULL_CLASS && n.c_fb == 7'h00) begin
               n.sel = abd_pkg::SUPER_WIDE_CLASS;
            end
            if (n.sel == abd_pkg::SUPER_WIDE_CLASS && n.c_swb == 7'h00) begin
               n.sel = abd_pkg::WIDE_CLASS;
               n.c_fb = 7'h00;
            end
            n.st = abd_pkg::ST_LIMIT;
         end
         abd_pkg::ST_LIMIT: begin
            // Clamp to what the bitrate supports and strobe the result.
            b = (rate == 2'b00) ? abd_pkg::NARROW_CLASS : r.sel;
            if (b == abd_pkg::FULL_CLASS && (r.bitrate == `ABD_BR_9K6 || r.bitrate < `ABD_BR_FB_MIN)) begin
               b = abd_pkg::SUPER_WIDE_CLASS;
            end
            if (b == abd_pkg::SUPER_WIDE_CLASS && r.bitrate < `ABD_BR_SWB_MIN) begin
               b = abd_pkg::WIDE_CLASS;
            end
            if (b == abd_pkg::NARROW_CLASS && r.bitrate > `ABD_BR_NB_MAX) begin
               b = abd_pkg::WIDE_CLASS;
            end
            n.bw = b;
            n.bw_vld = 1'b1;
            n.frames = r.frames + 8'h01;
            n.st = abd_pkg::ST_IDLE;
         end
         default: n.st = abd_pkg::ST_IDLE;
      endcase
      n.bin_rdy = (n.st == abd_pkg::ST_IDLE);
   end

   // ------------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         r <= '0;
         r.ctrl <= `ABD_CTRL_RST;
         r.bitrate <= `ABD_BITRATE_RST;
         r.bin_rdy <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign PRDATA_O = r.prdata;
   assign PREADY_O = r.pready;
   assign PSLVERR_O = r.pslverr;
   assign BIN_READY_O = r.bin_rdy;
   assign SELECTED_BANDWIDTH_O = r.bw;
   assign BW_VALID_O = r.bw_vld;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   sequence s_pass_start;
      r.st == abd_pkg::ST_IDLE && FRAME_DONE_I && r.ctrl[`ABD_EN_BIT] && rate != 2'b00;
   endsequence

   sequence s_start_8k;
      r.st == abd_pkg::ST_IDLE && FRAME_DONE_I && r.ctrl[`ABD_EN_BIT] && rate == 2'b00 &&
         r.bitrate <= `ABD_BR_NB_MAX && !(PSEL_I && PENABLE_I && PWRITE_I);
   endsequence

   a_pass_latency: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      s_pass_start |-> !BW_VALID_O [*8] ##1 !BW_VALID_O [*7] ##1 BW_VALID_O)
      else $error("result strobe not 15 cycles after frame");

   a_valid_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      BW_VALID_O |=> !BW_VALID_O) else $error("result strobe longer than one cycle");

   a_rate_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      s_start_8k |-> ##2 (BW_VALID_O && SELECTED_BANDWIDTH_O == 2'b00 && r.c_wb == $past(r.c_wb, 2)))
      else $error("8 kHz frame ran detection or was not narrow");

   a_counter_sat: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      r.c_wb <= `ABD_CNT_MAX && r.c_swb <= `ABD_CNT_MAX && r.c_fb <= `ABD_CNT_MAX)
      else $error("counter above 100");

   a_fb_clamp: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      BW_VALID_O && $past(r.bitrate) == `ABD_BR_9K6 |-> SELECTED_BANDWIDTH_O != 2'b11)
      else $error("full class at 9.6 kbps");

   a_nb_limit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      BW_VALID_O && SELECTED_BANDWIDTH_O == 2'b00 |-> $past(r.bitrate) <= `ABD_BR_NB_MAX)
      else $error("narrow class above its bitrate");

   a_fb_limit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      BW_VALID_O && SELECTED_BANDWIDTH_O == 2'b11 |-> $past(r.bitrate) >= `ABD_BR_FB_MIN)
      else $error("full class below its bitrate");

   a_ltm_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      r.st == abd_pkg::ST_LTM && !(r.activity_decision && r.noise_ok) |=> $stable(r.lt_nb) && $stable(r.lt_wb) &&
         $stable(r.lt_swb)) else $error("long-term mean moved while gated");

   a_band_floor: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      r.st == abd_pkg::ST_CLASS && rate == 2'b10 |-> r.lg[7] == `ABD_LOG_FLOOR && r.lg[8] == `ABD_LOG_FLOOR)
      else $error("band beyond rate was computed");

endmodule
